// ---- logic/sif_interlock_top.sv ----
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module sif_interlock_top #(
  parameter int unsigned CYC_PER_MS_P = sif_pkg::CYC_PER_MS
) (
  input  wire logic                            clk,
  input  wire logic                            arst_n,
  input  wire logic [sif_pkg::ADDR_W-1:0]      paddr,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic                            reset_button,
  input  wire logic [sif_pkg::SEL_W-1:0]       pair_select_inputs_a,
  input  wire logic [sif_pkg::SEL_W-1:0]       pair_select_inputs_b,
  input  wire logic [sif_pkg::NPAIR-1:0]       field_occupied_a,
  input  wire logic [sif_pkg::NPAIR-1:0]       field_occupied_b,
  output logic                                 safety_switch_output_a,
  output logic                                 safety_switch_output_b,
  output logic                                 diag_fault_a,
  output logic                                 diag_fault_b,
  output logic      [sif_pkg::PAIR_W-1:0]      active_pair_a,
  output logic      [sif_pkg::PAIR_W-1:0]      active_pair_b,
  output logic                                 irq
);
  import sif_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [CTRL_W-1:0]  ctrl;
  logic [TMR_W-1:0]   chg_time;
  logic [TMR_W-1:0]   resp_time;
  logic [IRQ_W-1:0]   irq_stat;
  logic [IRQ_W-1:0]   irq_mask;
  logic [IRQ_W-1:0]   irq_ev;
  logic [31:0]        ms_cnt;
  logic               ms_tick;
  logic               db;
  logic               db_prev;
  logic               armed;
  logic [DEB_W-1:0]   deb_cnt;
  logic               reset_edge;
  sif_startup_t       startup;
  logic               wr_en;
  logic               mapped;
  logic [31:0]        next_rdata;
  logic [SEL_W-1:0]   sel      [NUM_FUNC];
  logic [NPAIR-1:0]   occ      [NUM_FUNC];
  sif_mode_t          mode     [NUM_FUNC];
  sif_chg_t           state    [NUM_FUNC];
  logic [PAIR_W-1:0]  active   [NUM_FUNC];
  logic [PAIR_W-1:0]  prev     [NUM_FUNC];
  logic               hold_old [NUM_FUNC];
  logic [TMR_W-1:0]   chg_tmr  [NUM_FUNC];
  logic [HOLD_W-1:0]  holdoff  [NUM_FUNC];
  logic [SEL_W-1:0]   sel_q    [NUM_FUNC];
  logic               fault    [NUM_FUNC];
  logic               fault_q  [NUM_FUNC];
  logic               viol     [NUM_FUNC];
  logic               trip     [NUM_FUNC];
  logic               locked   [NUM_FUNC];
  logic               out      [NUM_FUNC];
  logic               out_q    [NUM_FUNC];
  assign sel[0]  = pair_select_inputs_a;
  assign sel[1]  = pair_select_inputs_b;
  assign occ[0]  = field_occupied_a;
  assign occ[1]  = field_occupied_b;
  assign startup = sif_startup_t'(ctrl[CTRL_START_LSB +: 2]);
  // millisecond time base shared by every timer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ms_cnt  <= 32'h0000_0000;
      ms_tick <= 1'b0;
    end else if (ms_cnt >= CYC_PER_MS_P - 1) begin
      ms_cnt  <= 32'h0000_0000;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt  <= ms_cnt + 32'h0000_0001;
      ms_tick <= 1'b0;
    end
  end
  // reset button debounce; armed once the debounced level is low, which it is from reset, so a button
  // held through power-up or stuck high still gives one press once it has been stable for the debounce time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      db      <= 1'b0;
      db_prev <= 1'b0;
      armed   <= 1'b0;
      deb_cnt <= 8'h00;
    end else begin
      db_prev <= db;
      if (!db) begin
        armed <= 1'b1;
      end
      if (reset_button == db) begin
        deb_cnt <= 8'h00;
      end else if (ms_tick) begin
        if (deb_cnt >= DEB_W'(DEBOUNCE_MS - 1)) begin
          db      <= reset_button;
          deb_cnt <= 8'h00;
        end else begin
          deb_cnt <= deb_cnt + 8'h01;
        end
      end
    end
  end
  assign reset_edge = db & ~db_prev & armed;
  debounce_edge_a: assert property (
    reset_edge |-> $past(reset_button) && $past(reset_button, 2))
    else $error("reset acted on without a stable press");
  // per protective function; both share the same changeover rules
  for (genvar f = 0; f < NUM_FUNC; f++) begin : g_func
    logic [PAIR_W-1:0] dec;
    logic [2:0]        n_on;
    logic [SEL_W-1:0]  new_bits;
    logic [HOLD_W-1:0] hold_load;
    assign mode[f]   = sif_mode_t'(ctrl[CTRL_MODE_LSB + 2*f +: 2]);
    assign dec       = sif_decode_pair(sel[f]);
    assign n_on      = sif_ones(sel[f]);
    assign new_bits  = sel[f] & ~(SEL_RST << active[f]);
    assign hold_load = {1'b0, resp_time} + HOLD_W'(SYNC_MS);
    // old pair stays watched in overlap; new pair ignored during holdoff
    assign viol[f] = ((holdoff[f] == '0) & occ[f][active[f]]) |
                     (hold_old[f] & occ[f][prev[f]]);
    assign trip[f] = viol[f] | fault[f];
    // changeover supervision
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        state[f]    <= CHG_IDLE;
        active[f]   <= 4'h0;
        prev[f]     <= 4'h0;
        hold_old[f] <= 1'b0;
        chg_tmr[f]  <= 16'h0000;
        holdoff[f]  <= 17'h00000;
        sel_q[f]    <= SEL_RST;
        fault[f]    <= 1'b0;
      end else begin
        if (ms_tick && chg_tmr[f] != '0) begin
          chg_tmr[f] <= chg_tmr[f] - 16'h0001;
        end
        if (ms_tick && holdoff[f] != '0) begin
          holdoff[f] <= holdoff[f] - 17'h00001;
        end
        // clear first so a fault raised in the same cycle survives
        if (reset_edge) begin
          fault[f] <= 1'b0;
        end
        case (mode[f])
          MODE_FIXED: begin
            active[f]   <= 4'h0;
            hold_old[f] <= 1'b0;
            state[f]    <= CHG_IDLE;
          end
          MODE_OVERLAP: begin
            if (n_on == 3'h1 && dec < 4'h5) begin
              if (dec != active[f]) begin
                prev[f]    <= active[f];
                active[f]  <= dec;
                holdoff[f] <= hold_load;
              end
              hold_old[f] <= 1'b0;
              state[f]    <= CHG_IDLE;
            end else if (n_on == 3'h2 && state[f] == CHG_IDLE &&
                         new_bits != sel[f]) begin
              // new pair joins while the old one stays selected
              state[f]    <= CHG_RUN;
              chg_tmr[f]  <= chg_time;
              prev[f]     <= active[f];
              active[f]   <= sif_decode_pair(new_bits);
              hold_old[f] <= 1'b1;
              holdoff[f]  <= hold_load;
            end else if (n_on == 3'h2 && state[f] == CHG_RUN) begin
              if (chg_tmr[f] == '0) begin
                fault[f] <= 1'b1;
              end
            end else begin
              fault[f] <= 1'b1;
            end
          end
          MODE_MOMENT: begin
            if (sel[f] != sel_q[f]) begin
              sel_q[f]   <= sel[f];
              state[f]   <= CHG_RUN;
              chg_tmr[f] <= chg_time;
            end else if (state[f] == CHG_RUN && chg_tmr[f] == '0) begin
              state[f] <= CHG_IDLE;
              if (dec == PAIR_NONE) begin
                fault[f] <= 1'b1;
              end else if (dec != active[f]) begin
                prev[f]    <= active[f];
                active[f]  <= dec;
                holdoff[f] <= hold_load;
              end
            end
            hold_old[f] <= 1'b0;
          end
          default: begin
            fault[f] <= 1'b1;
          end
        endcase
      end
    end
    // start and restart lockout
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        locked[f] <= 1'b1;
      end else begin
        case (startup)
          START_AUTO: begin
            locked[f] <= 1'b0;
          end
          START_INTLK: begin
            if (reset_edge && !trip[f]) begin
              locked[f] <= 1'b0;
            end
          end
          START_RELOCK: begin
            if (trip[f]) begin
              locked[f] <= 1'b1;
            end else if (reset_edge) begin
              locked[f] <= 1'b0;
            end
          end
          default: begin
            locked[f] <= 1'b1;
          end
        endcase
      end
    end
    // output drive and edge history for the event bits
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        out[f]     <= 1'b0;
        out_q[f]   <= 1'b0;
        fault_q[f] <= 1'b0;
      end else begin
        out[f]     <= ~locked[f] & ~trip[f];
        out_q[f]   <= out[f];
        fault_q[f] <= fault[f];
      end
    end
    assign irq_ev[IRQ_FAULT_LSB + f] = fault[f] & ~fault_q[f];
    assign irq_ev[IRQ_OFF_LSB + f]   = out_q[f] & ~out[f];
    sequence s_auto_clear;
      (startup == START_AUTO && !trip[f])[*2];
    endsequence
    sequence s_held_lock;
      locked[f] && !reset_edge && $stable(startup) &&
      (startup == START_INTLK || startup == START_RELOCK);
    endsequence
    start_lock_a: assert property (
      s_held_lock |=> locked[f] ##1 !out[f])
      else $error("lockout released without reset press");
    restart_relock_a: assert property (
      (startup == START_RELOCK && trip[f]) |=> locked[f] [*1] ##1 !out[f])
      else $error("restart interlock failed to relock");
    auto_rel_a: assert property (s_auto_clear |=> out[f])
      else $error("automatic restart did not release output");
    fixed_pair_a: assert property (
      mode[f] == MODE_FIXED |=> active[f] == 4'h0)
      else $error("fixed mode left the first pair");
    fault_off_a: assert property (fault[f] |=> !out[f])
      else $error("output on while changeover fault set");
    overlap_tmo_a: assert property (
      (mode[f] == MODE_OVERLAP && $stable(mode[f]) && state[f] == CHG_RUN
       && chg_tmr[f] == '0 && n_on == 3'h2) |=> fault[f])
      else $error("overlap left two pairs past changeover time");
    old_pair_a: assert property (
      (mode[f] == MODE_MOMENT && state[f] == CHG_RUN &&
       chg_tmr[f] != '0) ##1 $stable(mode[f]) |-> $stable(active[f]))
      else $error("pair switched before changeover time expired");
    moment_bad_a: assert property (
      (mode[f] == MODE_MOMENT && state[f] == CHG_RUN && chg_tmr[f] == '0
       && sel[f] == sel_q[f] && dec == PAIR_NONE) |=> fault[f])
      else $error("illegal selection pattern accepted");
    sync_delay_a: assert property (
      (mode[f] != MODE_FIXED && $stable(mode[f]) && $changed(active[f]))
      |-> holdoff[f] == {1'b0, $past(resp_time)} + HOLD_W'(SYNC_MS))
      else $error("new pair evaluated without synchronisation delay");
  end
  assign safety_switch_output_a = out[0];
  assign safety_switch_output_b = out[1];
  assign diag_fault_a           = fault[0];
  assign diag_fault_b           = fault[1];
  assign active_pair_a          = active[0];
  assign active_pair_b          = active[1];
  // apb slave: zero wait states, read data latched in the setup phase
  assign wr_en   = psel & penable & pwrite;
  assign mapped  = (paddr == ADDR_CTRL) || (paddr == ADDR_CHG_TIME) ||
                   (paddr == ADDR_RESP) || (paddr == ADDR_STATUS) ||
                   (paddr == ADDR_IRQ_STAT) || (paddr == ADDR_IRQ_MASK);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  // read mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      ADDR_CTRL:     next_rdata[CTRL_W-1:0] = ctrl;
      ADDR_CHG_TIME: next_rdata[TMR_W-1:0]  = chg_time;
      ADDR_RESP:     next_rdata[TMR_W-1:0]  = resp_time;
      ADDR_STATUS: begin
        next_rdata[ST_OUT_LSB +: 2]   = {out[1], out[0]};
        next_rdata[ST_FAULT_LSB +: 2] = {fault[1], fault[0]};
        next_rdata[ST_PAIR_LSB +: 8]  = {active[1], active[0]};
        next_rdata[ST_LOCK_LSB +: 2]  = {locked[1], locked[0]};
      end
      ADDR_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
      ADDR_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
      default:       next_rdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_rdata;
    end
  end
  // configuration registers; changeover time and response time in ms
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl      <= CTRL_RST;
      chg_time  <= CHG_TIME_RST;
      resp_time <= RESP_RST;
      irq_mask  <= 4'h0;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CTRL:     ctrl      <= pwdata[CTRL_W-1:0];
        ADDR_CHG_TIME: chg_time  <= pwdata[TMR_W-1:0];
        ADDR_RESP:     resp_time <= pwdata[TMR_W-1:0];
        ADDR_IRQ_MASK: irq_mask  <= pwdata[IRQ_W-1:0];
        default:       ctrl      <= ctrl;
      endcase
    end
  end
  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat <= 4'h0;
    end else if (wr_en && paddr == ADDR_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat <= irq_stat | irq_ev;
    end
  end
  assign irq = |(irq_stat & irq_mask);
endmodule // sif_interlock_top

// ---- logic/sif_pkg.sv ----
package sif_pkg;

  // clock and time base
  localparam int unsigned CLK_NS      = 40;
  localparam int unsigned MS_NS       = 1000000;
  localparam int unsigned CYC_PER_MS  = MS_NS / CLK_NS;
  localparam int unsigned SYNC_MS     = 40;
  localparam int unsigned DEBOUNCE_MS = 10;

  // geometry
  localparam int unsigned NUM_FUNC = 2;
  localparam int unsigned SEL_W    = 5;
  localparam int unsigned PAIR_W   = 4;
  localparam int unsigned NPAIR    = 10;
  localparam int unsigned TMR_W    = 16;
  localparam int unsigned HOLD_W   = 17;
  localparam int unsigned DEB_W    = 8;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned IRQ_W    = 4;

  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_CHG_TIME = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_RESP     = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 12'h00c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h014;

  // control fields and reset values
  localparam int unsigned CTRL_W         = 6;
  localparam int unsigned CTRL_START_LSB = 0;
  localparam int unsigned CTRL_MODE_LSB  = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST     = 6'h02;
  localparam logic [TMR_W-1:0]  CHG_TIME_RST = 16'h0064;
  localparam logic [TMR_W-1:0]  RESP_RST     = 16'h0050;

  // status fields
  localparam int unsigned ST_OUT_LSB   = 0;
  localparam int unsigned ST_FAULT_LSB = 2;
  localparam int unsigned ST_PAIR_LSB  = 4;
  localparam int unsigned ST_LOCK_LSB  = 12;

  // interrupt bits
  localparam int unsigned IRQ_FAULT_LSB = 0;
  localparam int unsigned IRQ_OFF_LSB   = 2;

  localparam logic [PAIR_W-1:0] PAIR_NONE = 4'hf;
  localparam logic [SEL_W-1:0]  SEL_RST   = 5'h01;

  typedef enum logic [1:0] {
    START_AUTO   = 2'b00,
    START_INTLK  = 2'b01,
    START_RELOCK = 2'b10
  } sif_startup_t;

  typedef enum logic [1:0] {
    MODE_FIXED   = 2'b00,
    MODE_OVERLAP = 2'b01,
    MODE_MOMENT  = 2'b10
  } sif_mode_t;

  typedef enum logic {
    CHG_IDLE = 1'b0,
    CHG_RUN  = 1'b1
  } sif_chg_t;

  // selection pattern to pair index, PAIR_NONE when not a legal pattern
  function automatic logic [PAIR_W-1:0] sif_decode_pair(
    input logic [SEL_W-1:0] s);
    case (s)
      5'h01:   sif_decode_pair = 4'h0;
      5'h02:   sif_decode_pair = 4'h1;
      5'h04:   sif_decode_pair = 4'h2;
      5'h08:   sif_decode_pair = 4'h3;
      5'h10:   sif_decode_pair = 4'h4;
      5'h0f:   sif_decode_pair = 4'h5;
      5'h17:   sif_decode_pair = 4'h6;
      5'h1b:   sif_decode_pair = 4'h7;
      5'h1d:   sif_decode_pair = 4'h8;
      5'h1e:   sif_decode_pair = 4'h9;
      default: sif_decode_pair = PAIR_NONE;
    endcase
  endfunction

  function automatic logic [2:0] sif_ones(input logic [SEL_W-1:0] s);
    sif_ones = 3'h0;
    for (int i = 0; i < SEL_W; i++) begin
      sif_ones = sif_ones + {2'h0, s[i]};
    end
  endfunction

endpackage

// ---- tb/sif_ctrl_model.sv ----
`timescale 1ns/1ns
// machine control side: drives pair selection and the operator button
module sif_ctrl_model
  import sif_pkg::*;
#(
  parameter int unsigned DEB_CYC = 100
) (
  input  wire logic                   clk,
  output logic      [sif_pkg::SEL_W-1:0] sel_a,
  output logic      [sif_pkg::SEL_W-1:0] sel_b,
  output logic                        button
);
  // legal patterns, one-hot then one-low, index is the pair number
  localparam logic [SEL_W-1:0] PAT [10] = '{5'h01, 5'h02, 5'h04, 5'h08,
    5'h10, 5'h0f, 5'h17, 5'h1b, 5'h1d, 5'h1e};

  // first pair selected and button released before reset ends
  initial begin
    sel_a  = 5'h01;
    sel_b  = 5'h01;
    button = 1'b0;
  end

  // selection only through the select lines, legal codes only
  task automatic select(input int a, input int b);
    @(posedge clk);
    sel_a <= PAT[a];
    sel_b <= PAT[b];
  endtask

  // raw pattern, used where a test wants a broken changeover or a change that fixed mode ignores
  task automatic raw_a(input logic [SEL_W-1:0] p);
    @(posedge clk);
    sel_a <= p;
  endtask

  // raw pattern on the b lines, for an illegal code in moment mode
  task automatic raw_b(input logic [SEL_W-1:0] p);
    @(posedge clk);
    sel_b <= p;
  endtask

  // new pair joins before the old one drops, never three at once
  task automatic make_before_break(input int nxt, input int dwell);
    @(posedge clk);
    sel_a <= sel_a | PAT[nxt];
    repeat (dwell) @(posedge clk);
    sel_a <= PAT[nxt];
  endtask

  // held well past the debounce time, then released just as long
  task automatic press();
    @(posedge clk);
    button <= 1'b1;
    repeat (DEB_CYC + 20) @(posedge clk);
    button <= 1'b0;
    repeat (DEB_CYC + 20) @(posedge clk);
  endtask
endmodule // sif_ctrl_model

// ---- tb/tb_safety_interlock_field_select.sv ----
`timescale 1ns/1ns
module tb_safety_interlock_field_select;
  import sif_pkg::*;
  // 10 cycles per ms keeps debounce and holdoff short
  localparam int unsigned CPM = 10;
  logic              clk;
  logic              arst_n;
  logic [ADDR_W-1:0] paddr;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              reset_button;
  logic [SEL_W-1:0]  sel_a;
  logic [SEL_W-1:0]  sel_b;
  logic [NPAIR-1:0]  field_occupied_a;
  logic [NPAIR-1:0]  field_occupied_b;
  logic              out_a;
  logic              out_b;
  logic              fault_a;
  logic              fault_b;
  logic [PAIR_W-1:0] pair_a;
  logic [PAIR_W-1:0] pair_b;
  logic              irq;
  logic [31:0]       rdat;
  logic              rerr;
  int                n_fail;
  int                samples_checked;
  int                prev;

  always #20 clk = ~clk;

  sif_interlock_top #(.CYC_PER_MS_P(CPM)) dut_u (
    .clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_button(reset_button),
    .pair_select_inputs_a(sel_a), .pair_select_inputs_b(sel_b),
    .field_occupied_a(field_occupied_a), .field_occupied_b(field_occupied_b),
    .safety_switch_output_a(out_a), .safety_switch_output_b(out_b),
    .diag_fault_a(fault_a), .diag_fault_b(fault_b),
    .active_pair_a(pair_a), .active_pair_b(pair_b), .irq(irq));

  sif_ctrl_model #(.DEB_CYC(10 * CPM)) ctrl_u (
    .clk(clk), .sel_a(sel_a), .sel_b(sel_b), .button(reset_button));

  // verdict in one place
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic test_end(input string name);
    $display("test %s done at %0t", name, $time);
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_fail++;
      $display("FAIL %0t bus transfer never answered", $time);
      final_report();
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp,
                    input string what);
    apb(1'b0, a, 32'h0);
    check(rdat, exp, what);
  endtask

  task automatic out_is(input logic exp, input string what);
    check({31'h0, out_a}, {31'h0, exp}, what);
  endtask

  // main sequence
  initial begin
    n_fail = 0;
    samples_checked = 0;
    clk = 1'b0;
    arst_n = 1'b0;
    paddr = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    field_occupied_a = '0;
    field_occupied_b = '0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    // reset values, unmapped access, short timers
    rd(ADDR_CTRL, {26'h0, CTRL_RST}, "ctrl reset");
    rd(ADDR_CHG_TIME, {16'h0, CHG_TIME_RST}, "chg time reset");
    rd(ADDR_RESP, {16'h0, RESP_RST}, "resp reset");
    rd(ADDR_IRQ_MASK, 32'h0, "mask reset");
    rd(12'h018, 32'h0, "unmapped data");
    check({31'h0, rerr}, 32'h1, "unmapped error");
    wr(ADDR_CHG_TIME, 32'h5);
    wr(ADDR_RESP, 32'h2);
    rd(ADDR_CHG_TIME, 32'h5, "chg time readback");
    test_end("registers");
    // outputs stay off until the operator presses
    cyc(300);
    out_is(1'b0, "off at power-up");
    ctrl_u.press();
    out_is(1'b1, "released by press");
    test_end("start interlock");
    // violation then clear: still locked until pressed again
    field_occupied_a <= 10'h001;
    cyc(3);
    out_is(1'b0, "off on violation");
    field_occupied_a <= 10'h000;
    cyc(300);
    out_is(1'b0, "held off after clear");
    ctrl_u.press();
    out_is(1'b1, "released after clear");
    test_end("restart interlock");
    // automatic restart, fixed pair ignores the inputs
    wr(ADDR_CTRL, 32'h0);
    field_occupied_a <= 10'h001;
    cyc(3);
    out_is(1'b0, "auto off on violation");
    field_occupied_a <= 10'h000;
    cyc(5);
    out_is(1'b1, "auto back on");
    ctrl_u.raw_a(5'h02);
    cyc(60);
    check({28'h0, pair_a}, 32'h0, "fixed pair");
    ctrl_u.raw_a(5'h01);
    test_end("auto restart and fixed");
    // fixed moment on both functions, every pair code
    wr(ADDR_CTRL, 32'h2a);
    cyc(5);
    prev = 0;
    for (int i = 1; i <= 10; i++) begin
      ctrl_u.select(i % 10, 9 - (i % 10));
      cyc(20);
      check({28'h0, pair_a}, prev, "old pair kept");
      cyc(40);
      check({28'h0, pair_a}, i % 10, "pair a");
      check({28'h0, pair_b}, 9 - (i % 10), "pair b");
      prev = i % 10;
    end
    test_end("fixed moment");
    // changeover onto an occupied pair trips only after the holdoff
    ctrl_u.press();
    field_occupied_a <= 10'h002;
    ctrl_u.select(1, 9);
    cyc(60);
    check({28'h0, pair_a}, 32'h1, "occupied pair taken");
    cyc(350);
    out_is(1'b1, "on during holdoff");
    cyc(100);
    out_is(1'b0, "off after holdoff");
    field_occupied_a <= 10'h000;
    ctrl_u.press();
    test_end("occupied changeover");
    // overlapped monitoring, then a broken changeover with interrupt
    wr(ADDR_CTRL, 32'h26);
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_IRQ_STAT, 32'hf);
    ctrl_u.make_before_break(2, 20);
    cyc(60);
    check({28'h0, pair_a}, 32'h2, "overlap pair");
    check({31'h0, fault_a}, 32'h0, "no fault");
    ctrl_u.raw_a(5'h0c);
    cyc(80);
    check({31'h0, fault_a}, 32'h1, "fault flagged");
    out_is(1'b0, "off on fault");
    check({31'h0, irq}, 32'h1, "irq raised");
    rd(ADDR_IRQ_STAT, 32'h5, "irq status");
    wr(ADDR_IRQ_STAT, 32'h5);
    cyc(2);
    check({31'h0, irq}, 32'h0, "irq cleared");
    test_end("overlap fault");
    // start interlock with automatic restart; illegal code on b
    wr(ADDR_CTRL, 32'h21);
    ctrl_u.press();
    out_is(1'b0, "first press only clears fault");
    ctrl_u.press();
    out_is(1'b1, "second press releases");
    check({31'h0, out_b}, 32'h1, "b stays on");
    // outputs both on, pair b is index 9, no faults, none locked
    rd(ADDR_STATUS, 32'h0000_0903, "status");
    field_occupied_a <= 10'h001;
    cyc(3);
    out_is(1'b0, "intlk off on violation");
    field_occupied_a <= 10'h000;
    cyc(5);
    out_is(1'b1, "intlk restarts by itself");
    ctrl_u.raw_b(5'h03);
    cyc(80);
    check({31'h0, fault_b}, 32'h1, "b illegal code");
    check({31'h0, out_b}, 32'h0, "b off on fault");
    test_end("start interlock auto restart");
    final_report();
  end
endmodule // tb_safety_interlock_field_select
